// [shared/wwm_pkg.sv]
`default_nettype none
package wwm_pkg;

  // Register bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int CNT_W  = 16;
  localparam int EVT_W  = 8;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TICK_DIV = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_TMO      = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_DP       = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_FLT      = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_EVENTS   = 8'h18;

  // Field positions
  localparam int CTRL_VARIANT_B_BIT = 0;
  localparam int EVT_DP_LSB         = 8;

  // Reset values: one tick is 1000 cycles (4 us at 250 MHz)
  localparam logic [DATA_W-1:0] TICK_DIV_RST = 32'h0000_03e8;
  localparam logic [CNT_W-1:0]  TMO_RST      = 16'h0010;
  localparam logic [CNT_W-1:0]  DP_RST       = 16'h0004;
  localparam logic [CNT_W-1:0]  FLT_RST      = 16'h0008;
  localparam logic              CTRL_RST     = 1'b0;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Watchdog states
  typedef enum logic [2:0] {
    ST_INIT   = 3'h0,
    ST_POR    = 3'h1,
    ST_IDLE   = 3'h2,
    ST_OPEN   = 3'h3,
    ST_CLOSED = 3'h4,
    ST_FAULT  = 3'h5
  } wwm_state_type;

  // Synchronised pin levels
  typedef struct packed {
    logic trig;
    logic wen;
    logic adj_tied_low;
    logic adj_tied_high;
    logic cur_ge_act;
    logic cur_le_deact;
    logic supply_ok;
    logic uv_reset_n;
  } wwm_pins_type;

  localparam int PINS_W = $bits(wwm_pins_type);

  // Status word as software sees it
  typedef struct packed {
    logic [23:0]   zero;
    logic          ticking;
    logic          auto_active;
    logic          fault_low;
    logic          monitor_on;
    logic [0:0]    spare;
    wwm_state_type state;
  } wwm_status_type;

  // Byte-lane merge for AXI write strobes
  function automatic logic [DATA_W-1:0] merge_bytes(input logic [DATA_W-1:0] old_val,
                                                    input logic [DATA_W-1:0] new_val,
                                                    input logic [3:0]        strb);
    logic [DATA_W-1:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (strb[i])
      begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge_bytes

endpackage : wwm_pkg
`default_nettype wire

// [core/wwm_sync3.sv]
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser; the output moves only when stages two and three agree
module wwm_sync3 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Asynchronous levels in, filtered levels out
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);

  logic [W-1:0] s1;
  logic [W-1:0] s2;
  logic [W-1:0] s3;
  logic [W-1:0] agree;

  // Stage one feeds only stage two
  assign agree = ~(s2 ^ s3);

  // Reset to low so an unconnected pin reads low
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      q  <= '0;
    end
    else
    begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      q  <= (agree & s3) | (~agree & q);
    end
  end

endmodule : wwm_sync3
`default_nettype wire

// [core/wwm_top.sv]
`timescale 1ns/1ps
`default_nettype none
module wwm_top (
  // Clock and reset
  input  wire logic        CLK,
  input  wire logic        RSTN,
  // Pins from the outside world (asynchronous)
  input  wire logic        TRIGGER_INPUT,
  input  wire logic        ENABLE_INPUT,
  input  wire logic        ADJ_TIED_LOW,
  input  wire logic        ADJ_TIED_HIGH,
  input  wire logic        CUR_GE_ACT,
  input  wire logic        CUR_LE_DEACT,
  input  wire logic        SUPPLY_OK,
  input  wire logic        UNDERVOLTAGE_RESET_N,
  // Watchdog outputs
  output var  logic        FAULT_OUTPUT_N,
  output var  logic        COMBINED_FAULT_RESET_N,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output var  logic        S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output var  logic        S_AXI_WREADY,
  // AXI4-Lite write response
  output var  logic [1:0]  S_AXI_BRESP,
  output var  logic        S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  // AXI4-Lite read
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output var  logic        S_AXI_ARREADY,
  output var  logic [31:0] S_AXI_RDATA,
  output var  logic [1:0]  S_AXI_RRESP,
  output var  logic        S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);

  localparam int CW = wwm_pkg::CNT_W;
  localparam int EW = wwm_pkg::EVT_W;

  wwm_pkg::wwm_pins_type   pins_raw;
  wwm_pkg::wwm_pins_type   pins;
  wwm_pkg::wwm_state_type  state;
  wwm_pkg::wwm_state_type  next_state;
  wwm_pkg::wwm_status_type status_word;

  // Software registers
  logic                    variant_b;
  logic [31:0]             tick_div;
  logic [CW-1:0]           tmo_ticks;
  logic [CW-1:0]           dp_ticks;
  logic [CW-1:0]           flt_ticks;
  logic [EW-1:0]           tmo_events;
  logic [EW-1:0]           dp_events;

  // Watchdog datapath
  logic                    trig_prev;
  logic                    trig_rise;
  logic                    trig_accept;
  logic                    auto_active;
  logic                    next_auto_active;
  logic                    adj_status;
  logic                    enable_level;
  logic                    monitor_en;
  logic                    ticking;
  logic                    restart;
  logic [31:0]             tick_cnt;
  logic [31:0]             tick_last;
  logic                    tick;
  logic [CW-1:0]           tmo_cnt;
  logic [CW-1:0]           win_cnt;
  logic                    tmo_hit;
  logic                    dp_hit;
  logic                    flt_hit;
  logic                    fault_entry_tmo;
  logic                    fault_entry_dp;

  // Bus datapath
  logic                    write_fire;
  logic                    read_fire;
  logic                    aw_take;
  logic                    ar_take;
  logic                    wr_mapped;
  logic                    rd_mapped;
  logic [31:0]             rd_value;

  // Pins enter through a three-flop filter; an open pin resets low
  assign pins_raw = '{trig:          TRIGGER_INPUT,
                      wen:           ENABLE_INPUT,
                      adj_tied_low:  ADJ_TIED_LOW,
                      adj_tied_high: ADJ_TIED_HIGH,
                      cur_ge_act:    CUR_GE_ACT,
                      cur_le_deact:  CUR_LE_DEACT,
                      supply_ok:     SUPPLY_OK,
                      uv_reset_n:    UNDERVOLTAGE_RESET_N};

  wwm_sync3 #(
    .W (wwm_pkg::PINS_W)
  ) u_sync (
    .clk   (CLK),
    .rst_n (RSTN),
    .d     (pins_raw),
    .q     (pins)
  );

  // Edge from two successive filtered samples
  assign trig_rise = pins.trig & ~trig_prev;

  // Enable path: variant A uses the enable pin, variant B the adjust status
  assign enable_level = variant_b ? adj_status : (pins.wen & auto_active);
  assign monitor_en   = pins.supply_ok & enable_level;

  // Adjust pin mode: tied low unused, tied high always, otherwise autonomous
  assign adj_status = pins.adj_tied_high ? 1'b1 :
                      pins.adj_tied_low  ? 1'b0 : auto_active;

  // Comparator with hysteresis: set at activation, cleared at deactivation
  assign next_auto_active = (!variant_b && !pins.wen) ? 1'b0 :
                            pins.cur_ge_act   ? 1'b1 :
                            pins.cur_le_deact ? 1'b0 :
                            auto_active;

  // Time base runs only while a window or a fault is being timed
  assign ticking   = (state == wwm_pkg::ST_OPEN) || (state == wwm_pkg::ST_CLOSED) ||
                     (state == wwm_pkg::ST_FAULT);
  assign restart   = (state == wwm_pkg::ST_IDLE);
  assign tick_last = (tick_div == 32'h0000_0000) ? 32'h0000_0000 : tick_div - 32'h0000_0001;
  assign tick      = ticking && (tick_cnt >= tick_last);

  // Window comparisons in ticks
  assign tmo_hit = (tmo_cnt >= tmo_ticks);
  assign dp_hit  = (win_cnt >= dp_ticks);
  assign flt_hit = (win_cnt >= flt_ticks);

  // Edges count only while monitored, output high and ticking
  assign trig_accept = trig_rise && monitor_en &&
                       ((state == wwm_pkg::ST_OPEN) || (state == wwm_pkg::ST_CLOSED));

  assign fault_entry_tmo = (state == wwm_pkg::ST_OPEN) && monitor_en && !trig_accept && tmo_hit;
  assign fault_entry_dp  = (state == wwm_pkg::ST_CLOSED) && monitor_en && trig_accept;

  // State transitions; undervoltage overrides every state
  always_comb
  begin
    next_state = state;
    if (!pins.supply_ok)
    begin
      next_state = wwm_pkg::ST_INIT;
    end
    else
    begin
      unique case (state)
        wwm_pkg::ST_INIT:
          next_state = wwm_pkg::ST_POR;
        wwm_pkg::ST_POR:
          next_state = wwm_pkg::ST_IDLE;
        wwm_pkg::ST_IDLE:
          if (monitor_en)
          begin
            next_state = wwm_pkg::ST_OPEN;
          end
        wwm_pkg::ST_OPEN:
          if (!monitor_en)
          begin
            next_state = wwm_pkg::ST_IDLE;
          end
          else if (trig_accept)
          begin
            next_state = wwm_pkg::ST_CLOSED;
          end
          else if (tmo_hit)
          begin
            next_state = wwm_pkg::ST_FAULT;
          end
        wwm_pkg::ST_CLOSED:
          if (!monitor_en)
          begin
            next_state = wwm_pkg::ST_IDLE;
          end
          else if (trig_accept)
          begin
            next_state = wwm_pkg::ST_FAULT;
          end
          else if (dp_hit)
          begin
            next_state = wwm_pkg::ST_OPEN;
          end
        wwm_pkg::ST_FAULT:
          if (flt_hit)
          begin
            next_state = monitor_en ? wwm_pkg::ST_OPEN : wwm_pkg::ST_IDLE;
          end
        default:
          next_state = wwm_pkg::ST_INIT;
      endcase
    end
  end

  // State, hysteresis flop and trigger history
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      state       <= wwm_pkg::ST_INIT;
      auto_active <= 1'b0;
      trig_prev   <= 1'b0;
    end
    else
    begin
      state       <= next_state;
      auto_active <= next_auto_active;
      trig_prev   <= pins.trig;
    end
  end

  // Base tick divider stands in for one capacitor charge-discharge cycle
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      tick_cnt <= 32'h0000_0000;
    end
    else if (!ticking || restart || tick)
    begin
      tick_cnt <= 32'h0000_0000;
    end
    else
    begin
      tick_cnt <= tick_cnt + 32'h0000_0001;
    end
  end

  // Timeout runs from window start or last trigger, across the closed window
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      tmo_cnt <= '0;
    end
    else if ((next_state != wwm_pkg::ST_OPEN && next_state != wwm_pkg::ST_CLOSED) ||
             trig_accept || (state != wwm_pkg::ST_OPEN && state != wwm_pkg::ST_CLOSED))
    begin
      tmo_cnt <= '0;
    end
    else if (tick && !tmo_hit)
    begin
      tmo_cnt <= tmo_cnt + 16'h0001;
    end
  end

  // Closed-window and fault-low time restart on every state change
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      win_cnt <= '0;
    end
    else if (next_state != state)
    begin
      win_cnt <= '0;
    end
    else if (tick && (win_cnt != 16'hffff))
    begin
      win_cnt <= win_cnt + 16'h0001;
    end
  end

  // Outputs come from flops fed by the next state so they track it exactly
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      FAULT_OUTPUT_N         <= 1'b1;
      COMBINED_FAULT_RESET_N <= 1'b0;
    end
    else
    begin
      FAULT_OUTPUT_N         <= (next_state != wwm_pkg::ST_FAULT);
      COMBINED_FAULT_RESET_N <= (next_state != wwm_pkg::ST_FAULT) & pins.uv_reset_n;
    end
  end

  // Fault event tallies for software; they wrap
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      tmo_events <= '0;
      dp_events  <= '0;
    end
    else
    begin
      tmo_events <= tmo_events + {{(EW-1){1'b0}}, fault_entry_tmo};
      dp_events  <= dp_events + {{(EW-1){1'b0}}, fault_entry_dp};
    end
  end

  // Bus handshakes: address and data are taken together, one at a time
  assign aw_take    = S_AXI_AWVALID && S_AXI_WVALID && !S_AXI_AWREADY && !S_AXI_BVALID;
  assign write_fire = S_AXI_AWVALID && S_AXI_AWREADY;
  assign ar_take    = S_AXI_ARVALID && !S_AXI_ARREADY && !S_AXI_RVALID;
  assign read_fire  = S_AXI_ARVALID && S_AXI_ARREADY;

  // Write decode covers read-only words too so they answer OKAY
  assign wr_mapped = (S_AXI_AWADDR == wwm_pkg::OFS_CTRL)     ||
                     (S_AXI_AWADDR == wwm_pkg::OFS_STATUS)   ||
                     (S_AXI_AWADDR == wwm_pkg::OFS_TICK_DIV) ||
                     (S_AXI_AWADDR == wwm_pkg::OFS_TMO)      ||
                     (S_AXI_AWADDR == wwm_pkg::OFS_DP)       ||
                     (S_AXI_AWADDR == wwm_pkg::OFS_FLT)      ||
                     (S_AXI_AWADDR == wwm_pkg::OFS_EVENTS);
  assign rd_mapped = (S_AXI_ARADDR == wwm_pkg::OFS_CTRL)     ||
                     (S_AXI_ARADDR == wwm_pkg::OFS_STATUS)   ||
                     (S_AXI_ARADDR == wwm_pkg::OFS_TICK_DIV) ||
                     (S_AXI_ARADDR == wwm_pkg::OFS_TMO)      ||
                     (S_AXI_ARADDR == wwm_pkg::OFS_DP)       ||
                     (S_AXI_ARADDR == wwm_pkg::OFS_FLT)      ||
                     (S_AXI_ARADDR == wwm_pkg::OFS_EVENTS);

  // Status shows live watchdog state
  assign status_word = '{zero:        24'h00_0000,
                         ticking:     ticking,
                         auto_active: auto_active,
                         fault_low:   !FAULT_OUTPUT_N,
                         monitor_on:  monitor_en,
                         spare:       1'b0,
                         state:       state};

  // Read mux; unused upper bits read as zero
  assign rd_value =
    (S_AXI_ARADDR == wwm_pkg::OFS_CTRL)     ? {31'h0000_0000, variant_b} :
    (S_AXI_ARADDR == wwm_pkg::OFS_STATUS)   ? status_word :
    (S_AXI_ARADDR == wwm_pkg::OFS_TICK_DIV) ? tick_div :
    (S_AXI_ARADDR == wwm_pkg::OFS_TMO)      ? {16'h0000, tmo_ticks} :
    (S_AXI_ARADDR == wwm_pkg::OFS_DP)       ? {16'h0000, dp_ticks} :
    (S_AXI_ARADDR == wwm_pkg::OFS_FLT)      ? {16'h0000, flt_ticks} :
    (S_AXI_ARADDR == wwm_pkg::OFS_EVENTS)   ? {16'h0000, dp_events, tmo_events} :
                                              32'h0000_0000;

  // Write channel: ready pulses one cycle, response holds until taken
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      S_AXI_AWREADY <= 1'b0;
      S_AXI_WREADY  <= 1'b0;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= wwm_pkg::RESP_OKAY;
    end
    else
    begin
      S_AXI_AWREADY <= aw_take;
      S_AXI_WREADY  <= aw_take;
      if (write_fire)
      begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_mapped ? wwm_pkg::RESP_OKAY : wwm_pkg::RESP_SLVERR;
      end
      else if (S_AXI_BREADY)
      begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Register writes honour byte strobes; timing values take effect at once
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      variant_b <= wwm_pkg::CTRL_RST;
      tick_div  <= wwm_pkg::TICK_DIV_RST;
      tmo_ticks <= wwm_pkg::TMO_RST;
      dp_ticks  <= wwm_pkg::DP_RST;
      flt_ticks <= wwm_pkg::FLT_RST;
    end
    else if (write_fire)
    begin
      if (S_AXI_AWADDR == wwm_pkg::OFS_CTRL && S_AXI_WSTRB[0])
      begin
        variant_b <= S_AXI_WDATA[wwm_pkg::CTRL_VARIANT_B_BIT];
      end
      if (S_AXI_AWADDR == wwm_pkg::OFS_TICK_DIV)
      begin
        tick_div <= wwm_pkg::merge_bytes(tick_div, S_AXI_WDATA, S_AXI_WSTRB);
      end
      if (S_AXI_AWADDR == wwm_pkg::OFS_TMO)
      begin
        tmo_ticks <= CW'(wwm_pkg::merge_bytes({16'h0000, tmo_ticks}, S_AXI_WDATA, S_AXI_WSTRB));
      end
      if (S_AXI_AWADDR == wwm_pkg::OFS_DP)
      begin
        dp_ticks <= CW'(wwm_pkg::merge_bytes({16'h0000, dp_ticks}, S_AXI_WDATA, S_AXI_WSTRB));
      end
      if (S_AXI_AWADDR == wwm_pkg::OFS_FLT)
      begin
        flt_ticks <= CW'(wwm_pkg::merge_bytes({16'h0000, flt_ticks}, S_AXI_WDATA, S_AXI_WSTRB));
      end
    end
  end

  // Read channel: data captured with the address, held until taken
  always_ff @(posedge CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      S_AXI_ARREADY <= 1'b0;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h0000_0000;
      S_AXI_RRESP   <= wwm_pkg::RESP_OKAY;
    end
    else
    begin
      S_AXI_ARREADY <= ar_take;
      if (read_fire)
      begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA  <= rd_value;
        S_AXI_RRESP  <= rd_mapped ? wwm_pkg::RESP_OKAY : wwm_pkg::RESP_SLVERR;
      end
      else if (S_AXI_RREADY)
      begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end

endmodule : wwm_top
`default_nettype wire

// [verif/wwm_chk.sv]
`timescale 1ns/1ps
`default_nettype none
// Pin and bus-handshake checks at the watchdog top
module wwm_chk (
  // Clock and reset
  input wire logic        CLK,
  input wire logic        RSTN,
  // Watchdog pins
  input wire logic        SUPPLY_OK,
  input wire logic        FAULT_OUTPUT_N,
  input wire logic        COMBINED_FAULT_RESET_N,
  // Bus handshakes
  input wire logic        S_AXI_AWREADY,
  input wire logic        S_AXI_WREADY,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_ARREADY,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  // A low fault pin drags the combined pin down in the same cycle
  property p_comb; !FAULT_OUTPUT_N |-> !COMBINED_FAULT_RESET_N; endproperty
  a_comb: assert property (p_comb) else $error("combined pin high in fault");
  // Fault pulse is never shorter than eight cycles, whatever the enable does
  property p_flt; $fell(FAULT_OUTPUT_N) |-> !FAULT_OUTPUT_N [*8]; endproperty
  a_flt: assert property (p_flt) else $error("fault pulse cut short");
  // Sustained undervoltage parks the watchdog with the fault pin released
  property p_uv; !SUPPLY_OK [*8] |-> FAULT_OUTPUT_N; endproperty
  a_uv: assert property (p_uv) else $error("fault low under undervoltage");
  // Address and data are taken together
  property p_aw; $rose(S_AXI_AWREADY) |-> S_AXI_WREADY; endproperty
  a_aw: assert property (p_aw) else $error("write channels split");
  // Write answer follows the take by one cycle
  property p_b; S_AXI_AWREADY |=> S_AXI_BVALID && !S_AXI_AWREADY; endproperty
  a_b: assert property (p_b) else $error("write answer late");
  // Read answer follows the take by one cycle
  property p_r; S_AXI_ARREADY |=> S_AXI_RVALID && !S_AXI_ARREADY; endproperty
  a_r: assert property (p_r) else $error("read answer late");
  // Responses stand until accepted
  property p_bh; S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP); endproperty
  a_bh: assert property (p_bh) else $error("write answer dropped");
  property p_rh; S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA); endproperty
  a_rh: assert property (p_rh) else $error("read answer dropped");
endmodule : wwm_chk
`default_nettype wire

// [verif/wwm_mcu.sv]
`timescale 1ns/1ps
`default_nettype none
// Processor stand-in: one clean trigger pulse per request
module wwm_mcu (
  // Clock and request
  input  wire logic clk,
  input  wire logic go,
  // Trigger pin
  output var  logic trig
);
  logic [2:0] left = 3'h0;
  // Pulse outlasts the pin filter; idle level is low like the pulled-down pin
  always_ff @(posedge clk)
    left <= go ? 3'h6 : left - 3'(left != 3'h0);
  assign trig = (left != 3'h0);
endmodule : wwm_mcu
`default_nettype wire

// [verif/wwm_top_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module wwm_top_bench;
  // Pins, all inputs defined at time zero
  logic        CLK = 1'b0, RSTN = 1'b0, go = 1'b0, TRIGGER_INPUT;
  logic        ENABLE_INPUT = 1'b0, ADJ_TIED_LOW = 1'b0, ADJ_TIED_HIGH = 1'b0;
  logic        CUR_GE_ACT = 1'b0, CUR_LE_DEACT = 1'b0;
  logic        SUPPLY_OK = 1'b0, UNDERVOLTAGE_RESET_N = 1'b0;
  logic        FAULT_OUTPUT_N, COMBINED_FAULT_RESET_N;
  logic [7:0]  S_AXI_AWADDR = 8'h00, S_AXI_ARADDR = 8'h00;
  logic [31:0] S_AXI_WDATA = 32'h0, S_AXI_RDATA, d;
  logic [3:0]  S_AXI_WSTRB = 4'hf;
  logic        S_AXI_AWVALID = 1'b0, S_AXI_WVALID = 1'b0, S_AXI_BREADY = 1'b0;
  logic        S_AXI_ARVALID = 1'b0, S_AXI_RREADY = 1'b0;
  logic        S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
  logic [1:0]  S_AXI_BRESP, S_AXI_RRESP, r;
  int          err_total = 0, n_compared = 0, n;

  always #2 CLK = ~CLK;

  wwm_top i_dut (.CLK, .RSTN, .TRIGGER_INPUT, .ENABLE_INPUT, .ADJ_TIED_LOW,
    .ADJ_TIED_HIGH, .CUR_GE_ACT, .CUR_LE_DEACT, .SUPPLY_OK, .UNDERVOLTAGE_RESET_N,
    .FAULT_OUTPUT_N, .COMBINED_FAULT_RESET_N, .S_AXI_AWADDR, .S_AXI_AWVALID,
    .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WSTRB, .S_AXI_WVALID, .S_AXI_WREADY,
    .S_AXI_BRESP, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_ARADDR, .S_AXI_ARVALID,
    .S_AXI_ARREADY, .S_AXI_RDATA, .S_AXI_RRESP, .S_AXI_RVALID, .S_AXI_RREADY);
  wwm_mcu i_mcu (.clk(CLK), .go, .trig(TRIGGER_INPUT));

  task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, s, e);
    end
  endtask : chk

  // Both write channels offered at once; ready comes a cycle late so the held answer is seen
  task wr(input logic [7:0] a, input logic [31:0] v);
    S_AXI_AWADDR <= a;
    S_AXI_WDATA <= v;
    S_AXI_AWVALID <= 1'b1;
    S_AXI_WVALID <= 1'b1;
    do @(posedge CLK); while (S_AXI_AWREADY !== 1'b1);
    S_AXI_AWVALID <= 1'b0;
    S_AXI_WVALID <= 1'b0;
    @(posedge CLK);
    S_AXI_BREADY <= 1'b1;
    do @(posedge CLK); while (S_AXI_BVALID !== 1'b1);
    S_AXI_BREADY <= 1'b0;
    chk(32'(S_AXI_BRESP), 32'(wwm_pkg::RESP_OKAY));
    @(posedge CLK);
  endtask : wr

  task rd(input logic [7:0] a);
    S_AXI_ARADDR <= a;
    S_AXI_ARVALID <= 1'b1;
    do @(posedge CLK); while (S_AXI_ARREADY !== 1'b1);
    S_AXI_ARVALID <= 1'b0;
    @(posedge CLK);
    S_AXI_RREADY <= 1'b1;
    do @(posedge CLK); while (S_AXI_RVALID !== 1'b1);
    d = S_AXI_RDATA;
    r = S_AXI_RRESP;
    S_AXI_RREADY <= 1'b0;
    @(posedge CLK);
  endtask : rd

  task rc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(d, e);
    chk(32'(r), 32'(wwm_pkg::RESP_OKAY));
  endtask : rc

  // Poll the state field until it reads the expected state, bounded
  task wst(input wwm_pkg::wwm_state_type e);
    repeat (80)
    begin
      rd(wwm_pkg::OFS_STATUS);
      if (d[2:0] === e) break;
    end
    chk(32'(d[2:0]), 32'(e));
  endtask : wst

  // Measure a fault pulse: 8 ticks of 4 cycles, one tick of phase slack
  task fl(input logic dis);
    n = 0;
    while (FAULT_OUTPUT_N !== 1'b0) @(posedge CLK);
    if (dis) ENABLE_INPUT <= 1'b0;
    while (FAULT_OUTPUT_N === 1'b0)
    begin
      n++;
      @(posedge CLK);
    end
    chk(32'(n >= 28 && n <= 36), 32'h1);
  endtask : fl

  task pulse();
    go <= 1'b1;
    @(posedge CLK);
    go <= 1'b0;
  endtask : pulse

  task note(input string s);
    $display("test %s done", s);
  endtask : note

  task summarize();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  // Main sequence
  initial
  begin
    repeat (8) @(posedge CLK);
    RSTN <= 1'b1;
    @(posedge CLK);
    rc(wwm_pkg::OFS_CTRL, 32'h0);
    rc(wwm_pkg::OFS_TICK_DIV, wwm_pkg::TICK_DIV_RST);
    rc(wwm_pkg::OFS_TMO, 32'(wwm_pkg::TMO_RST));
    rc(wwm_pkg::OFS_DP, 32'(wwm_pkg::DP_RST));
    rc(wwm_pkg::OFS_FLT, 32'(wwm_pkg::FLT_RST));
    rd(8'h40);
    chk(32'(r), 32'(wwm_pkg::RESP_SLVERR));
    wr(wwm_pkg::OFS_TICK_DIV, 32'h4);
    S_AXI_WSTRB <= 4'h1;
    wr(wwm_pkg::OFS_TMO, 32'h0000_ab20);
    S_AXI_WSTRB <= 4'hf;
    rc(wwm_pkg::OFS_TMO, 32'h0000_0020);
    wr(wwm_pkg::OFS_TMO, 32'(wwm_pkg::TMO_RST));
    rc(wwm_pkg::OFS_TMO, 32'(wwm_pkg::TMO_RST));
    note("registers");
    SUPPLY_OK <= 1'b1;
    UNDERVOLTAGE_RESET_N <= 1'b1;
    ENABLE_INPUT <= 1'b1;
    CUR_GE_ACT <= 1'b1;
    wst(wwm_pkg::ST_OPEN);
    pulse();
    wst(wwm_pkg::ST_CLOSED);
    wst(wwm_pkg::ST_OPEN);
    chk(32'(FAULT_OUTPUT_N), 32'h1);
    chk(32'(COMBINED_FAULT_RESET_N), 32'h1);
    pulse();
    repeat (9) @(posedge CLK);
    pulse();
    fl(1'b0);
    rc(wwm_pkg::OFS_EVENTS, 32'h0000_0100);
    note("window");
    fl(1'b1);
    wst(wwm_pkg::ST_IDLE);
    rc(wwm_pkg::OFS_EVENTS, 32'h0000_0101);
    pulse();
    repeat (40) @(posedge CLK);
    wst(wwm_pkg::ST_IDLE);
    ENABLE_INPUT <= 1'b1;
    wst(wwm_pkg::ST_OPEN);
    repeat (40) @(posedge CLK);
    ENABLE_INPUT <= 1'b0;
    wst(wwm_pkg::ST_IDLE);
    ENABLE_INPUT <= 1'b1;
    wst(wwm_pkg::ST_OPEN);
    repeat (40) @(posedge CLK);
    rc(wwm_pkg::OFS_EVENTS, 32'h0000_0101);
    note("timeout");
    ENABLE_INPUT <= 1'b0;
    ADJ_TIED_LOW <= 1'b1;
    wst(wwm_pkg::ST_IDLE);
    wr(wwm_pkg::OFS_CTRL, 32'h1);
    wst(wwm_pkg::ST_IDLE);
    CUR_GE_ACT <= 1'b0;
    CUR_LE_DEACT <= 1'b1;
    ADJ_TIED_LOW <= 1'b0;
    ADJ_TIED_HIGH <= 1'b1;
    wst(wwm_pkg::ST_OPEN);
    ADJ_TIED_HIGH <= 1'b0;
    wst(wwm_pkg::ST_IDLE);
    CUR_LE_DEACT <= 1'b0;
    repeat (40) @(posedge CLK);
    wst(wwm_pkg::ST_IDLE);
    CUR_GE_ACT <= 1'b1;
    wst(wwm_pkg::ST_OPEN);
    UNDERVOLTAGE_RESET_N <= 1'b0;
    repeat (8) @(posedge CLK);
    chk(32'(COMBINED_FAULT_RESET_N), 32'h0);
    chk(32'(FAULT_OUTPUT_N), 32'h1);
    UNDERVOLTAGE_RESET_N <= 1'b1;
    SUPPLY_OK <= 1'b0;
    wst(wwm_pkg::ST_INIT);
    SUPPLY_OK <= 1'b1;
    wst(wwm_pkg::ST_OPEN);
    note("modes");
    summarize();
  end

  // Hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    #100000;
    err_total++;
    summarize();
  end
endmodule : wwm_top_bench

bind wwm_top wwm_chk i_chk (.CLK, .RSTN, .SUPPLY_OK, .FAULT_OUTPUT_N, .COMBINED_FAULT_RESET_N,
  .S_AXI_AWREADY, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_BREADY, .S_AXI_BRESP,
  .S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA);
`default_nettype wire
